// *** design/port_fc_pkg.sv ***
// Purpose: Shared constants and carriers for the port flow-control register block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Offsets, field positions and response codes live here only
package port_fc_pkg;

    localparam logic [11:0] PORT1_FLOW_CONTROL_OFFSET = 12'h1a0;
    localparam int          ADDR_W                    = 12;

    // Field positions inside the port flow-control word
    localparam int BP_EN_BIT      = 6;
    localparam int CUR_DUP_BIT    = 5;
    localparam int CUR_RX_BIT     = 4;
    localparam int CUR_TX_BIT     = 3;
    localparam int RX_EN_BIT      = 2;
    localparam int TX_EN_BIT      = 1;
    localparam int MANUAL_BIT     = 0;
    localparam logic [31:0] WRITABLE_MASK = 32'h0000_0047;

    // Values held during the asynchronous reset, before the straps are caught
    localparam logic RESET_BIT_VALUE = 1'b0;

    // Enabled edges after reset before the synchroniser shows real strap levels
    localparam logic [1:0] SYNC_FILL_CYCLES = 2'h2;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Strap set for one port, as sampled at reset or rewritten by the loader
    typedef struct packed {
        logic backpressure_strap;
        logic full_duplex_pause_strap;
        logic manual_pause_strap;
    } strap_s;

    // Link state from the PHY side of the port
    typedef struct packed {
        logic half_duplex;
        logic autoneg_enable;
        logic autoneg_done;
        logic partner_rx_pause;
        logic partner_tx_pause;
    } link_s;

    // Flow-control controls driven into the port MAC
    typedef struct packed {
        logic backpressure_enable;
        logic rx_pause_active;
        logic tx_pause_active;
    } fc_ctrl_s;

endpackage

// *** design/port_flow_control_config.sv ***
// Purpose: Port 1 flow-control configuration and status register on AXI4-Lite
// Assumes: Straps and link state arrive from pins or other domains and are synchronised
// Notes:   Clock enable low freezes every flip-flop including the bus handshake
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bit 6 turns half-duplex backpressure on the port on when 1 and off when 0.
// - Read-only bit 5 shows the real duplex, 0 for full and 1 for half.
// - Read-only bit 4 shows whether receive pause handling is active now.
// - Read-only bit 3 shows whether transmit pause generation is active now.
// - Bit 2 enables pause frame detection, used only in manual mode or without autoneg.
// - Bit 1 enables pause frame generation, used only in manual mode or without autoneg.
// - With manual select 0 and autoneg on, the negotiated result rules and bits 2 and 1 do not.
// - With manual select 1, bits 2 and 1 alone set flow control while in full duplex.
// - The writable bits take their reset values from straps caught at reset; the status bits reset to 0 and follow the link.
// - When the loader rewrites the straps, the register fields take the new strap values.
// - The status bits follow the flow control actually in force, manual or negotiated.
// - Writes here never touch the PHY autoneg advertisement flow-control values.
module port_flow_control_config
    import port_fc_pkg::*;
#(
    // Word offset of this port's register; the other ports reuse the block
    parameter logic [ADDR_W-1:0] REG_OFFSET = PORT1_FLOW_CONTROL_OFFSET
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_nrst,
    input  wire logic              i_ce,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // Straps, loader rewrite event and link state, all asynchronous
    input  wire strap_s            i_straps,
    input  wire logic              i_strap_reload_toggle,
    input  wire link_s             i_link,
    // Controls into the port MAC
    output var fc_ctrl_s           o_fc_ctrl
);

    localparam int SYNC_W = $bits(strap_s) + 1 + $bits(link_s);

    // Elaboration guard: the decode compares whole words, never the low two bits
    if (REG_OFFSET[1:0] != 2'h0) begin : g_offset_check
        $error("REG_OFFSET must be word aligned");
    end

    // Two-stage synchroniser for every asynchronous input
    // Straps share it with the toggle; they settle before the toggle moves
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    strap_s            straps_s;
    logic              reload_tog_s;
    link_s             link_sy;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (i_ce) begin
            sync1_reg <= {i_straps, i_strap_reload_toggle, i_link};
            sync2_reg <= sync1_reg;
        end
    end

    assign {straps_s, reload_tog_s, link_sy} = sync2_reg;

    // Strap capture: third enabled edge after release, once the synchroniser has filled, then on every loader toggle
    logic       capture_done_reg;
    logic       reload_tog_seen_reg;
    logic       load_straps;
    logic [1:0] sync_fill_reg;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            capture_done_reg    <= 1'b0;
            reload_tog_seen_reg <= 1'b0;
        end else if (i_ce) begin
            // Waits two cycles so the synchroniser holds real strap levels
            capture_done_reg    <= capture_done_reg | (sync_fill_reg == SYNC_FILL_CYCLES);
            reload_tog_seen_reg <= reload_tog_s;
        end
    end

    // Fill count: edges the synchroniser needs before straps can be trusted
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_fill_reg <= 2'h0;
        end else if (i_ce && sync_fill_reg != SYNC_FILL_CYCLES) begin
            sync_fill_reg <= sync_fill_reg + 2'h1;
        end
    end

    // One-cycle load pulse; the toggle is only trusted once capture is done
    assign load_straps = (!capture_done_reg && sync_fill_reg == SYNC_FILL_CYCLES)
                       || (capture_done_reg && reload_tog_s != reload_tog_seen_reg);

    // AXI write channel: address and data taken in either order
    logic                  aw_held_reg;
    logic                  w_held_reg;
    logic [ADDR_W-1:0]     awaddr_reg;
    logic [31:0]           wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  do_write;

    // Readies drop with the clock enable, so no item is lost while frozen
    assign o_awready = i_ce && !aw_held_reg && !o_bvalid;
    assign o_wready  = i_ce && !w_held_reg && !o_bvalid;
    assign do_write  = aw_held_reg && w_held_reg && !o_bvalid;

    // Write address slot
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= i_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    // Write data slot; may fill before or after the address
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (i_ce) begin
            if (i_wvalid && o_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= i_wdata;
                wstrb_reg  <= i_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Word decode shared by reads and writes
    function automatic logic hits_reg(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2] == REG_OFFSET[ADDR_W-1:2];
    endfunction

    // Write response; unmapped word answers SLVERR
    // Set cannot meet a clear: do_write needs bvalid low
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (i_ce) begin
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp  <= hits_reg(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Writable control bits; only byte lane 0 carries them
    logic backpressure_enable_reg;
    logic rx_pause_enable_reg;
    logic tx_pause_enable_reg;
    logic manual_pause_select_reg;
    logic sw_write;

    // Lane 0 masked: the write still answers OKAY but changes nothing
    assign sw_write = do_write && hits_reg(awaddr_reg) && wstrb_reg[0];

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            backpressure_enable_reg <= RESET_BIT_VALUE;
            rx_pause_enable_reg     <= RESET_BIT_VALUE;
            tx_pause_enable_reg     <= RESET_BIT_VALUE;
            manual_pause_select_reg <= RESET_BIT_VALUE;
        end else if (i_ce) begin
            if (load_straps) begin
                // Strap load wins over a write in the same cycle: it is the rarer event
                backpressure_enable_reg <= straps_s.backpressure_strap;
                rx_pause_enable_reg     <= straps_s.full_duplex_pause_strap;
                tx_pause_enable_reg     <= straps_s.full_duplex_pause_strap;
                manual_pause_select_reg <= straps_s.manual_pause_strap;
            end else if (sw_write) begin
                // Status and reserved bits of the write are dropped
                backpressure_enable_reg <= wdata_reg[BP_EN_BIT];
                rx_pause_enable_reg     <= wdata_reg[RX_EN_BIT];
                tx_pause_enable_reg     <= wdata_reg[TX_EN_BIT];
                manual_pause_select_reg <= wdata_reg[MANUAL_BIT];
            end
        end
    end

    // Flow control in force: manual bits or negotiated partner result
    logic use_manual;
    logic rx_active_next;
    logic tx_active_next;

    always_comb begin
        use_manual = manual_pause_select_reg || !link_sy.autoneg_enable;
        if (link_sy.half_duplex) begin
            // Pause frames mean nothing in half duplex
            rx_active_next = 1'b0;
            tx_active_next = 1'b0;
        end else if (use_manual) begin
            rx_active_next = rx_pause_enable_reg;
            tx_active_next = tx_pause_enable_reg;
        end else begin
            // Partner result counts only once negotiation has completed
            rx_active_next = link_sy.autoneg_done && link_sy.partner_rx_pause;
            tx_active_next = link_sy.autoneg_done && link_sy.partner_tx_pause;
        end
    end

    // Status and MAC controls registered from the same terms
    logic current_duplex_reg;
    logic current_rx_pause_active_reg;
    logic current_tx_pause_active_reg;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            current_duplex_reg          <= RESET_BIT_VALUE;
            current_rx_pause_active_reg <= RESET_BIT_VALUE;
            current_tx_pause_active_reg <= RESET_BIT_VALUE;
        end else if (i_ce) begin
            current_duplex_reg          <= link_sy.half_duplex;
            current_rx_pause_active_reg <= rx_active_next;
            current_tx_pause_active_reg <= tx_active_next;
        end
    end

    // MAC controls; backpressure matters only in half duplex
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fc_ctrl <= '0;
        end else if (i_ce) begin
            o_fc_ctrl.backpressure_enable <= backpressure_enable_reg && link_sy.half_duplex;
            o_fc_ctrl.rx_pause_active     <= rx_active_next;
            o_fc_ctrl.tx_pause_active     <= tx_active_next;
        end
    end

    // No path from here to the PHY advertisement: it has no output toward it

    // Read word assembly, reserved bits zero
    // Fields read straight from the registers, no extra delay
    logic [31:0] read_word;

    always_comb begin
        read_word             = 32'h0000_0000;
        read_word[BP_EN_BIT]  = backpressure_enable_reg;
        read_word[CUR_DUP_BIT] = current_duplex_reg;
        read_word[CUR_RX_BIT] = current_rx_pause_active_reg;
        read_word[CUR_TX_BIT] = current_tx_pause_active_reg;
        read_word[RX_EN_BIT]  = rx_pause_enable_reg;
        read_word[TX_EN_BIT]  = tx_pause_enable_reg;
        read_word[MANUAL_BIT] = manual_pause_select_reg;
    end

    // Read channel: one cycle to answer, held until rready
    // Arready waits for the clock enable too, like the write side
    assign o_arready = i_ce && !o_rvalid;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= RESP_OKAY;
        end else if (i_ce) begin
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata  <= hits_reg(i_araddr) ? read_word : 32'h0000_0000;
                o_rresp  <= hits_reg(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** test/port_fc_properties.sv ***
// Purpose: Bus handshake and register word checks for the port flow-control block
// Assumes: Sees only the top ports; clock enable high around a write
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module port_fc_properties
    import port_fc_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_nrst,
    input wire logic        i_ce,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic        i_rready
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic rd_go;
    logic wr_go;
    logic hit;
    // Handshake events as the design takes them
    assign rd_go = i_arvalid && o_arready && i_ce;
    assign wr_go = i_awvalid && o_awready && i_wvalid && o_wready && i_ce;
    assign hit   = i_araddr[11:2] == PORT1_FLOW_CONTROL_OFFSET[11:2];
    rsv_zero_a: assert property (
        o_rvalid && o_rresp == RESP_OKAY |-> o_rdata[31:7] == 25'h0) else $error("reserved bits set");
    half_quiet_a: assert property (
        o_rvalid && o_rdata[5] |-> o_rdata[4:3] == 2'h0) else $error("pause active in half duplex");
    bad_read_a: assert property (
        rd_go && !hit |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read");
    good_read_a: assert property (rd_go && hit |=> o_rresp == RESP_OKAY) else $error("mapped read");
    rd_answer_a: assert property (rd_go |=> o_rvalid) else $error("read not answered");
    wr_answer_a: assert property (wr_go ##1 i_ce |=> o_bvalid) else $error("write not answered");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (o_rvalid |-> !o_arready) else $error("read taken while busy");
    aw_block_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken");
    ce_gate_a: assert property (!i_ce |-> !o_awready && !o_wready && !o_arready)
        else $error("ready while frozen");
    cover property (o_rvalid && !i_rready);
    cover property (wr_go);
    cover property (rd_go && !hit);
    cover property (o_rvalid && o_rdata[5]);
endmodule
bind port_flow_control_config port_fc_properties u_props (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready));
`default_nettype wire

// *** test/port_flow_control_config_bench.sv ***
// Purpose: Self-checking bench for the port flow-control register
// Assumes: Ready lines high except in the slow-ready scenarios
// Notes:   Expected words come from straps, writes and link state
`timescale 1ns/1ps
`default_nettype none
module port_flow_control_config_bench;
    import port_fc_pkg::*;
    logic              i_mclk, i_nrst, i_ce, i_awvalid, i_wvalid, i_bready;
    logic              i_arvalid, i_rready, i_strap_reload_toggle;
    logic [ADDR_W-1:0] i_awaddr, i_araddr;
    logic [31:0]       i_wdata, o_rdata, rnd, d;
    logic [3:0]        i_wstrb, cfg;
    logic [1:0]        o_bresp, o_rresp;
    logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    strap_s            i_straps;
    link_s             i_link;
    fc_ctrl_s          o_fc_ctrl;
    int                num_errors, checks_done, cycles;
    logic [33:0]       rq[$], wq[$], e;
    localparam logic [11:0] REG_A = PORT1_FLOW_CONTROL_OFFSET;
    port_flow_control_config DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
        .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(i_rready), .i_straps(i_straps), .i_strap_reload_toggle(i_strap_reload_toggle),
        .i_link(i_link), .o_fc_ctrl(o_fc_ctrl));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Register word from config {bit6,bit2,bit1,bit0} and the link in force
    function automatic logic [33:0] exp_word(input logic [3:0] c, input link_s l);
        logic [1:0] st;
        if (l.half_duplex) st = 2'h0;
        else if (c[0] || !l.autoneg_enable) st = c[2:1];
        else st = {l.autoneg_done && l.partner_rx_pause, l.autoneg_done && l.partner_tx_pause};
        return {RESP_OKAY, 25'h0, c[3], l.half_duplex, st, c[2:1], c[0]};
    endfunction
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s,
                      input logic [1:0] r);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        wq.push_back({32'h0, r});
        i_awaddr <= a; i_wdata <= dv; i_wstrb <= s; i_awvalid <= 1'h1; i_wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready) begin ad = 1'h1; i_awvalid <= 1'h0; end
            if (i_wvalid && o_wready) begin wd = 1'h1; i_wvalid <= 1'h0; end
        end
        do @(posedge i_mclk); while (!o_bvalid);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] ev);
        rq.push_back(ev);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        do @(posedge i_mclk); while (!o_arready);
        i_arvalid <= 1'h0;
        do @(posedge i_mclk); while (!o_rvalid);
    endtask
    initial begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end
    // Response watcher pairs each answer with the oldest note
    always @(posedge i_mclk) begin
        if (o_bvalid && i_bready) chk("bresp", {32'h0, o_bresp}, wq.pop_front());
        if (o_rvalid && i_rready) chk("rdata", {o_rresp, o_rdata}, rq.pop_front());
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 4000) begin num_errors++; summarize(); end
    end
    initial begin
        rnd = 32'h0001_1d7a;
        i_nrst = 1'h0; i_ce = 1'h1; i_bready = 1'h1; i_rready = 1'h1;
        i_awvalid = 1'h0; i_wvalid = 1'h0; i_arvalid = 1'h0; i_strap_reload_toggle = 1'h0;
        i_awaddr = 12'h0; i_araddr = 12'h0; i_wdata = 32'h0; i_wstrb = 4'h0;
        i_straps = rnd[2:0]; i_link = rnd[8:4];
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'h1;
        repeat (8) @(posedge i_mclk);
        cfg = {i_straps.backpressure_strap, {2{i_straps.full_duplex_pause_strap}},
               i_straps.manual_pause_strap};
        rd(REG_A, exp_word(cfg, i_link));
        // Random writes over random link states, some with lane 0 masked off
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            i_link <= rnd[4:0];
            d = lfsr(rnd);
            rnd = d;
            wr(REG_A, d, (i % 4 == 3) ? 4'he : 4'hf, RESP_OKAY);
            if (i % 4 != 3) cfg = {d[6], d[2:1], d[0]};
            repeat (4) @(posedge i_mclk);
            e = exp_word(cfg, i_link);
            rd(REG_A, e);
            chk("fc_ctrl", {31'h0, o_fc_ctrl}, {31'h0, cfg[3] && i_link.half_duplex, e[4:3]});
        end
        // Slow write ready: the error answer must stand until taken
        i_bready <= 1'h0;
        wr(12'h1a4, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        repeat (2) @(posedge i_mclk);
        i_bready <= 1'h1;
        @(posedge i_mclk);
        rd(12'h1a4, {RESP_SLVERR, 32'h0});
        rd(REG_A, exp_word(cfg, i_link));
        // Frozen clock enable holds the read off; slow read ready then holds the answer
        i_ce <= 1'h0;
        i_rready <= 1'h0;
        fork
            rd(REG_A, exp_word(cfg, i_link));
            begin
                repeat (3) @(posedge i_mclk);
                i_ce <= 1'h1;
            end
        join
        repeat (3) @(posedge i_mclk);
        i_rready <= 1'h1;
        @(posedge i_mclk);
        // Loader rewrites the straps; fields must follow
        rnd = lfsr(rnd);
        i_straps <= ~i_straps;
        @(posedge i_mclk);
        i_strap_reload_toggle <= 1'h1;
        repeat (8) @(posedge i_mclk);
        cfg = {i_straps.backpressure_strap, {2{i_straps.full_duplex_pause_strap}},
               i_straps.manual_pause_strap};
        rd(REG_A, exp_word(cfg, i_link));
        repeat (2) @(posedge i_mclk);
        summarize();
    end
endmodule
`default_nettype wire
